/* logic/tma_arbiter.sv */
// Interrupt arbiter with two-level masking and exception entry sequencing.
// Summary of operation
// - UME=1 uses global mask; else both masks
// - NMI always accepted except reset or standby
// - Each source has an enable bit
// - Forward request only when condition and enable
// - UME=1: global mask blocks all maskable requests
// - Select highest programmed level, others stay pending
// - Equal levels resolved by fixed default order
// - Smaller vector number wins in default order
// - Priority bits programmable; reset gives default order
// - Entry starts after current instruction completes
// - Push return PC and condition codes
// - UME=1: set global mask after stack save
// - Form vector address, start routine from it
// - UME=0: level 0 masked by global mask
// - UME=0: level 1 masked only by both
// - UME=0, global mask clear: accept any request
// - UME=0: entry sets both mask bits
// - Decision takes 2 states external, 1 internal
// - Stack and vector take 4, 8, 12 states
// - Two prefetches together take 4, 8, 12 states
// - Four internal processing states, split in two
// - Wait states lengthen three-state accesses
`timescale 1ns/1ps
module tma_arbiter (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire tma_pkg::tma_apb_req_s i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_nmi,
    input wire logic [3:0] i_ext_req,
    input wire logic [24:0] i_per_req,
    input wire logic i_hw_standby,
    input wire logic i_wait,
    input wire logic i_insn_done,
    input wire logic [23:0] i_next_pc,
    output logic o_busy,
    output logic o_accept,
    output logic o_done,
    output tma_pkg::tma_phase_s o_phase,
    output logic [5:0] o_vector,
    output logic [15:0] o_vec_addr,
    output logic [23:0] o_saved_pc,
    output logic [7:0] o_saved_ccr,
    output logic [7:0] o_ccr
);

    // Picks the lowest index among the set bits, which is the smallest vector number.
    function automatic tma_pkg::tma_pick_s pick_first(input logic [28:0] cand);
        tma_pkg::tma_pick_s res;
        res = '0;
        for (int i = tma_pkg::NSRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                res.found = 1'b1;
                res.idx = i[4:0];
            end
        end
        return res;
    endfunction : pick_first

    // Length of a timed phase for the memory type latched when the request is selected in idle.
    function automatic logic [3:0] phase_len(input tma_pkg::tma_state_e s, input logic [1:0] mem);
        logic [3:0] acc;
        acc = (mem == tma_pkg::MEM_ONCHIP) ? tma_pkg::ACC_ONCHIP :
              (mem == tma_pkg::MEM_TWO) ? tma_pkg::ACC_TWO : tma_pkg::ACC_THREE;
        case (s)
            tma_pkg::ST_PROC_A, tma_pkg::ST_PROC_B: phase_len = tma_pkg::PROC_HALF;
            tma_pkg::ST_PREF_A, tma_pkg::ST_PREF_B: phase_len = {1'b0, acc[3:1]};
            tma_pkg::ST_STACK, tma_pkg::ST_VECTOR: phase_len = acc;
            default: phase_len = 4'h1;
        endcase
    endfunction : phase_len

    // Successor of each timed phase in the entry sequence.
    function automatic tma_pkg::tma_state_e phase_next(input tma_pkg::tma_state_e s);
        case (s)
            tma_pkg::ST_PROC_A: phase_next = tma_pkg::ST_PREF_A;
            tma_pkg::ST_PREF_A: phase_next = tma_pkg::ST_STACK;
            tma_pkg::ST_STACK: phase_next = tma_pkg::ST_MASK;
            tma_pkg::ST_MASK: phase_next = tma_pkg::ST_VECTOR;
            tma_pkg::ST_VECTOR: phase_next = tma_pkg::ST_PREF_B;
            tma_pkg::ST_PREF_B: phase_next = tma_pkg::ST_PROC_B;
            default: phase_next = tma_pkg::ST_IDLE;
        endcase
    endfunction : phase_next

    logic [1:0] nmi_sync;
    logic [1:0] stby_sync;
    logic [1:0] wait_sync;
    logic [15:0] prio_cat;
    logic [3:0] ext_sync_a4;
    logic [3:0] ext_sync_b;
    logic nmi_prev;
    logic nmi_pend;
    logic ume;
    logic [7:0] prio_a;
    logic [7:0] prio_b;
    logic [28:0] enable;
    logic [7:0] condition_code_reg;
    logic [1:0] memcfg;
    tma_pkg::tma_state_e state;
    logic [3:0] cnt;
    logic [1:0] acc_mem;
    logic [5:0] sel_vec;
    logic sel_is_nmi;
    logic stby;
    logic [28:0] req;
    logic [28:0] level;
    logic [28:0] elig;
    tma_pkg::tma_pick_s pick_hi;
    tma_pkg::tma_pick_s pick_lo;
    tma_pkg::tma_pick_s pick;
    logic pick_internal;
    logic gmask;
    logic umask;
    logic stall;
    logic wr_en;
    logic hw_mask_set;
    logic mapped;

    // Pins from outside the clock domain pass two flops; only the second one is read.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            nmi_sync <= 2'h0;
            stby_sync <= 2'h0;
            wait_sync <= 2'h0;
            ext_sync_a4 <= 4'h0;
            ext_sync_b <= 4'h0;
        end else begin
            nmi_sync <= {nmi_sync[0], i_nmi};
            stby_sync <= {stby_sync[0], i_hw_standby};
            wait_sync <= {wait_sync[0], i_wait};
            ext_sync_a4 <= i_ext_req;
            ext_sync_b <= ext_sync_a4;
        end
    end
    assign stby = stby_sync[1];

    // The non-maskable request is caught on its rising edge and held until taken or until standby clears it.
    // A new edge in the cycle of acceptance sets the flag again, so it is not lost.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            nmi_prev <= 1'b0;
            nmi_pend <= 1'b0;
        end else begin
            nmi_prev <= nmi_sync[1];
            if (stby) begin
                nmi_pend <= 1'b0;
            end else if (nmi_sync[1] && !nmi_prev) begin
                nmi_pend <= 1'b1;
            end else if (state == tma_pkg::ST_IDLE && nmi_pend) begin
                nmi_pend <= 1'b0;
            end
        end
    end

    // Both priority registers side by side, so one bit index names the level of a source.
    assign prio_cat = {prio_a, prio_b};

    // Requests count only with their enable bit; each gets its level from the priority bits.
    always_comb begin
        req = {i_per_req, ext_sync_b} & enable;
        for (int i = 0; i < tma_pkg::NSRC; i++) begin
            level[i] = prio_cat[tma_pkg::SRC_PBIT[i]];
        end
    end

    assign gmask = condition_code_reg[tma_pkg::GMASK_BIT];
    assign umask = condition_code_reg[tma_pkg::UMASK_BIT];

    // Mask filter: with UME set the global mask alone gates; without it level 1 needs both.
    always_comb begin
        if (ume) begin
            elig = gmask ? 29'h0000_0000 : req;
        end else if (!gmask) begin
            elig = req;
        end else if (!umask) begin
            elig = req & level;
        end else begin
            elig = 29'h0000_0000;
        end
    end

    // Level 1 sources win over level 0; inside a level the smaller vector wins.
    // Filtering before selection gives the same winner as select-then-mask, since a
    // masked level 1 request implies every level 0 request is masked as well.
    always_comb begin
        pick_hi = pick_first(elig & level);
        pick_lo = pick_first(elig & ~level);
        pick = pick_hi.found ? pick_hi : pick_lo;
        pick_internal = (pick.idx >= 5'(tma_pkg::NEXT_SRC));
    end

    // Wait states stretch only the memory phases and only for three-state memory.
    assign stall = wait_sync[1] && (acc_mem == tma_pkg::MEM_THREE) &&
        (state == tma_pkg::ST_PREF_A || state == tma_pkg::ST_STACK ||
         state == tma_pkg::ST_VECTOR || state == tma_pkg::ST_PREF_B);

    // Entry sequencer; standby drops any entry in progress and holds the block idle.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= tma_pkg::ST_IDLE;
            cnt <= 4'h0;
            acc_mem <= tma_pkg::MEM_ONCHIP;
            sel_vec <= 6'h00;
            sel_is_nmi <= 1'b0;
        end else if (stby) begin
            state <= tma_pkg::ST_IDLE;
            cnt <= 4'h0;
        end else begin
            case (state)
                tma_pkg::ST_IDLE: begin
                    // Idle looks at the masks again every cycle, so a held request goes
                    // as soon as it is unmasked.
                    if (nmi_pend) begin
                        state <= tma_pkg::ST_DECIDE;
                        cnt <= tma_pkg::DECIDE_EXT;
                        sel_vec <= tma_pkg::NMI_VEC;
                        sel_is_nmi <= 1'b1;
                        acc_mem <= memcfg;
                    end else if (pick.found) begin
                        state <= tma_pkg::ST_DECIDE;
                        cnt <= pick_internal ? tma_pkg::DECIDE_INT : tma_pkg::DECIDE_EXT;
                        sel_vec <= tma_pkg::SRC_VEC[pick.idx];
                        sel_is_nmi <= 1'b0;
                        acc_mem <= memcfg;
                    end
                end
                tma_pkg::ST_DECIDE: begin
                    if (cnt == 4'h1) begin
                        state <= tma_pkg::ST_WAIT_INSN;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                tma_pkg::ST_WAIT_INSN: begin
                    if (i_insn_done) begin
                        state <= tma_pkg::ST_PROC_A;
                        cnt <= phase_len(tma_pkg::ST_PROC_A, acc_mem);
                    end
                end
                default: begin
                    if (!stall) begin
                        if (cnt == 4'h1) begin
                            state <= phase_next(state);
                            cnt <= phase_len(phase_next(state), acc_mem);
                        end else begin
                            cnt <= cnt - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Return address and condition codes are captured at the instruction boundary.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_saved_pc <= 24'h00_0000;
            o_saved_ccr <= 8'h00;
        end else if (state == tma_pkg::ST_WAIT_INSN && i_insn_done && !stby) begin
            o_saved_pc <= i_next_pc;
            o_saved_ccr <= condition_code_reg;
        end
    end

    // Vector number and its address appear once the masks are updated.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_vector <= 6'h00;
            o_vec_addr <= 16'h0000;
        end else if (state == tma_pkg::ST_MASK && !stby) begin
            o_vector <= sel_vec;
            o_vec_addr <= {8'h00, sel_vec, 2'b00};
        end
    end

    // Phase strobes, acceptance and completion pulses.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_accept <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_accept <= !stby && state == tma_pkg::ST_WAIT_INSN && i_insn_done;
            o_done <= !stby && state == tma_pkg::ST_PROC_B && cnt == 4'h1;
        end
    end
    assign o_busy = (state != tma_pkg::ST_IDLE);
    assign o_phase.internal = (state == tma_pkg::ST_PROC_A || state == tma_pkg::ST_PROC_B);
    assign o_phase.prefetch = (state == tma_pkg::ST_PREF_A || state == tma_pkg::ST_PREF_B);
    assign o_phase.stack_save = (state == tma_pkg::ST_STACK);
    assign o_phase.vector_fetch = (state == tma_pkg::ST_VECTOR);

    // APB decode; the bus never waits, so reads are staged in the setup cycle.
    assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign hw_mask_set = (state == tma_pkg::ST_MASK) && !stby;
    always_comb begin
        case (i_apb.paddr)
            tma_pkg::OFF_SYSCTL, tma_pkg::OFF_PRIO_A, tma_pkg::OFF_PRIO_B, tma_pkg::OFF_ENABLE,
            tma_pkg::OFF_CCR, tma_pkg::OFF_MEMCFG, tma_pkg::OFF_STATUS,
            tma_pkg::OFF_PENDING: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign o_pready = 1'b1;
    assign o_pslverr = i_apb.psel && i_apb.penable && !mapped;

    // Control registers; the hardware mask update wins over a same-cycle write.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ume <= tma_pkg::SYSCTL_RST;
            prio_a <= tma_pkg::PRIO_RST;
            prio_b <= tma_pkg::PRIO_RST;
            enable <= tma_pkg::ENABLE_RST;
            memcfg <= tma_pkg::MEMCFG_RST;
        end else if (wr_en) begin
            case (i_apb.paddr)
                tma_pkg::OFF_SYSCTL: ume <= i_apb.pwdata[tma_pkg::UME_BIT];
                tma_pkg::OFF_PRIO_A: prio_a <= i_apb.pwdata[7:0];
                tma_pkg::OFF_PRIO_B: prio_b <= i_apb.pwdata[7:0];
                tma_pkg::OFF_ENABLE: enable <= i_apb.pwdata[28:0];
                tma_pkg::OFF_MEMCFG: memcfg <= i_apb.pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Condition codes: software writes, exception entry raises the global mask bit, and with UME clear the other mask bit too.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            condition_code_reg <= tma_pkg::CCR_RST;
        end else begin
            if (wr_en && i_apb.paddr == tma_pkg::OFF_CCR) begin
                condition_code_reg <= i_apb.pwdata[7:0];
            end
            if (hw_mask_set) begin
                condition_code_reg[tma_pkg::GMASK_BIT] <= 1'b1;
                if (!ume) begin
                    condition_code_reg[tma_pkg::UMASK_BIT] <= 1'b1;
                end
            end
        end
    end
    assign o_ccr = condition_code_reg;

    // Read data is taken in the setup cycle and stands through the access cycle.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
            case (i_apb.paddr)
                tma_pkg::OFF_SYSCTL: o_prdata <= {31'h0000_0000, ume};
                tma_pkg::OFF_PRIO_A: o_prdata <= {24'h00_0000, prio_a};
                tma_pkg::OFF_PRIO_B: o_prdata <= {24'h00_0000, prio_b};
                tma_pkg::OFF_ENABLE: o_prdata <= {3'h0, enable};
                tma_pkg::OFF_CCR: o_prdata <= {24'h00_0000, condition_code_reg};
                tma_pkg::OFF_MEMCFG: o_prdata <= {30'h0000_0000, memcfg};
                tma_pkg::OFF_STATUS: o_prdata <= {16'h0000, nmi_pend, sel_is_nmi, sel_vec,
                    4'h0, 4'(state)};
                tma_pkg::OFF_PENDING: o_prdata <= {3'h0, req};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks next to the logic; each watches what this block drives.
    sequence s_stack_onchip;
        (state == tma_pkg::ST_STACK)[*4] ##1 state == tma_pkg::ST_MASK;
    endsequence
    sequence s_proc_a;
        (state == tma_pkg::ST_PROC_A)[*2] ##1 state == tma_pkg::ST_PREF_A;
    endsequence

    property p_nmi_taken;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_IDLE && nmi_pend) |=> (state == tma_pkg::ST_DECIDE && sel_is_nmi);
    endproperty
    a_nmi_taken: assert property (p_nmi_taken) else $error("NMI not taken from idle.");

    property p_enabled_only;
        @(posedge i_mclk) disable iff (!i_rstn)
        pick.found |-> enable[pick.idx];
    endproperty
    a_enabled_only: assert property (p_enabled_only) else $error("Disabled source chosen.");

    property p_ume_gmask;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_IDLE && ume && gmask && !nmi_pend) |=> state == tma_pkg::ST_IDLE;
    endproperty
    a_ume_gmask: assert property (p_ume_gmask) else $error("Masked request started.");

    property p_level1_only;
        @(posedge i_mclk) disable iff (!i_rstn)
        (!ume && gmask && !umask && pick.found) |-> level[pick.idx];
    endproperty
    a_level1_only: assert property (p_level1_only) else $error("Level 0 passed the mask.");

    property p_wait_insn;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_WAIT_INSN && !i_insn_done) |=> state == tma_pkg::ST_WAIT_INSN;
    endproperty
    a_wait_insn: assert property (p_wait_insn) else $error("Entry before boundary.");

    property p_mask_set;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_MASK) |=> (gmask && (ume || umask) && o_vector == sel_vec);
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("Mask bits not raised.");

    property p_decide_ext;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_IDLE && nmi_pend) |=> (state == tma_pkg::ST_DECIDE)[*2]
            ##1 state == tma_pkg::ST_WAIT_INSN;
    endproperty
    a_decide_ext: assert property (p_decide_ext) else $error("Decision not two states.");

    property p_stack_onchip;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_STACK && $past(state) == tma_pkg::ST_PREF_A &&
         acc_mem == tma_pkg::MEM_ONCHIP) |-> s_stack_onchip;
    endproperty
    a_stack_onchip: assert property (p_stack_onchip) else $error("Stack save length wrong.");

    property p_proc_a;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_WAIT_INSN && i_insn_done) |=> s_proc_a;
    endproperty
    a_proc_a: assert property (p_proc_a) else $error("Internal phase not two states.");

    // A peripheral request needs only one decision state before the boundary wait.
    sequence s_decide_one;
        state == tma_pkg::ST_DECIDE ##1 state == tma_pkg::ST_WAIT_INSN;
    endsequence

    property p_decide_int;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        (state == tma_pkg::ST_IDLE && !nmi_pend && pick.found && pick_internal)
            |=> s_decide_one;
    endproperty
    a_decide_int: assert property (p_decide_int) else $error("Decision not one state.");

    // A stalled memory phase keeps both its state and its count.
    property p_wait_hold;
        @(posedge i_mclk) disable iff (!i_rstn || stby)
        stall |=> ($stable(state) && $stable(cnt));
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("Stalled phase moved on.");

endmodule : tma_arbiter

/* logic/tma_pkg.sv */
// Package with the register map, source table, timing counts and carriers of the arbiter.
package tma_pkg;

    // Number of maskable sources: four request pins and twenty-five peripheral events.
    localparam int NSRC = 29;
    localparam int NEXT_SRC = 4;

    // Register byte offsets on the APB.
    localparam logic [7:0] OFF_SYSCTL = 8'h00;
    localparam logic [7:0] OFF_PRIO_A = 8'h04;
    localparam logic [7:0] OFF_PRIO_B = 8'h08;
    localparam logic [7:0] OFF_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_CCR = 8'h10;
    localparam logic [7:0] OFF_MEMCFG = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_PENDING = 8'h1C;

    // Field positions.
    localparam int UME_BIT = 0;
    localparam int GMASK_BIT = 7;
    localparam int UMASK_BIT = 6;

    // Reset values.
    localparam logic SYSCTL_RST = 1'h1;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [28:0] ENABLE_RST = 29'h0000_0000;
    localparam logic [7:0] CCR_RST = 8'h80;
    localparam logic [1:0] MEMCFG_RST = 2'h0;

    // Memory types that set the access counts.
    localparam logic [1:0] MEM_ONCHIP = 2'h0;
    localparam logic [1:0] MEM_TWO = 2'h1;
    localparam logic [1:0] MEM_THREE = 2'h2;

    // Timing counts in states, one state per clock.
    localparam logic [3:0] ACC_ONCHIP = 4'h4;
    localparam logic [3:0] ACC_TWO = 4'h8;
    localparam logic [3:0] ACC_THREE = 4'hC;
    localparam logic [3:0] DECIDE_EXT = 4'h2;
    localparam logic [3:0] DECIDE_INT = 4'h1;
    localparam logic [3:0] PROC_HALF = 4'h2;

    // Vector numbers, index 28 first, and the priority bit of each source in {prio_a, prio_b}.
    localparam logic [5:0] NMI_VEC = 6'h07;
    localparam logic [28:0][5:0] SRC_VEC = {
        6'h3C, 6'h3B, 6'h3A, 6'h39, 6'h38, 6'h37, 6'h36, 6'h35, 6'h34, 6'h2A,
        6'h29, 6'h28, 6'h26, 6'h25, 6'h24, 6'h22, 6'h21, 6'h20, 6'h1E, 6'h1D,
        6'h1C, 6'h1A, 6'h19, 6'h18, 6'h14, 6'h11, 6'h10, 6'h0D, 6'h0C};
    localparam logic [28:0][3:0] SRC_PBIT = {
        4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h6,
        4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9,
        4'h9, 4'hA, 4'hA, 4'hA, 4'hB, 4'hC, 4'hC, 4'hE, 4'hF};

    typedef enum logic [3:0] {
        ST_IDLE, ST_DECIDE, ST_WAIT_INSN, ST_PROC_A, ST_PREF_A,
        ST_STACK, ST_MASK, ST_VECTOR, ST_PREF_B, ST_PROC_B
    } tma_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tma_apb_req_s;

    typedef struct packed {
        logic internal;
        logic prefetch;
        logic stack_save;
        logic vector_fetch;
    } tma_phase_s;

    typedef struct packed {
        logic found;
        logic [4:0] idx;
    } tma_pick_s;

endpackage : tma_pkg

/* dv/tma_core_model.sv */
// Core model that marks instruction boundaries and return addresses.
`timescale 1ns/1ps
module tma_core_model (
    input wire logic i_mclk,
    input wire logic i_rstn,
    output logic o_insn_done,
    output logic [23:0] o_next_pc
);
    // One instruction ends every fourth cycle, so entry must wait for it.
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_insn_done <= 1'b0;
            o_next_pc <= 24'h00_0100;
        end else begin
            o_insn_done <= (o_next_pc[1:0] == 2'h2);
            o_next_pc <= o_next_pc + 24'h00_0001;
        end
    end
endmodule : tma_core_model

/* dv/tb_tma_arbiter.sv */
// Self-checking bench for the interrupt arbiter.
`timescale 1ns/1ps
module tb_tma_arbiter;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    tma_pkg::tma_apb_req_s apb = '0;
    logic nmi = 1'b0;
    logic [3:0] ext = 4'h0;
    logic [24:0] per = 25'h000_0000;
    logic stby = 1'b0;
    logic wt = 1'b0;
    int hold = 0;
    logic idone, pready, pslverr, busy, acc, done, err;
    logic [23:0] npc, spc;
    logic [31:0] prdata, rd;
    tma_pkg::tma_phase_s phase;
    logic [5:0] vec;
    logic [15:0] vad;
    logic [7:0] sccr, condition_code_reg;
    int n_errors = 0;
    int samples_checked = 0;

    tma_arbiter dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_apb(apb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_nmi(nmi), .i_ext_req(ext),
        .i_per_req(per), .i_hw_standby(stby), .i_wait(wt), .i_insn_done(idone),
        .i_next_pc(npc), .o_busy(busy), .o_accept(acc), .o_done(done), .o_phase(phase),
        .o_vector(vec), .o_vec_addr(vad), .o_saved_pc(spc), .o_saved_ccr(sccr), .o_ccr(condition_code_reg));
    tma_core_model core (.i_mclk(i_mclk), .i_rstn(i_rstn), .o_insn_done(idone),
        .o_next_pc(npc));

    // Free-running 20 MHz clock.
    always #25 i_mclk = ~i_mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request stands until pready is seen high.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_mclk);
        apb.penable <= 1'b1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb <= '0;
    endtask : xfer

    // Waits a bounded time for entry, then times it from accept to done.
    // A nonzero hold raises the wait pin for that many cycles right after acceptance.
    task automatic serve(input logic ex, input logic [5:0] v, input int dur);
        int n;
        int ns;
        int nv;
        n = 0;
        ns = 0;
        nv = 0;
        while (acc !== 1'b1 && n < 60) begin
            @(posedge i_mclk);
            n++;
        end
        chk(acc, ex);
        if (ex) begin
            chk(spc + 24'h00_0001, npc);
            chk(busy, 1'b1);
            chk(phase, 4'h8);
            if (hold > 0)
                wt <= 1'b1;
            n = 0;
            while (done !== 1'b1 && n < 60) begin
                @(posedge i_mclk);
                n++;
                ns += phase.stack_save;
                nv += phase.vector_fetch;
                if (n == hold)
                    wt <= 1'b0;
            end
            chk(n, dur);
            chk(ns, (dur - 5 - hold) / 3);
            chk(nv, (dur - 5 - hold) / 3);
            chk(busy, 1'b0);
            chk(vec, v);
            chk(vad, {8'h00, v, 2'b00});
        end
    endtask : serve

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // A hang is far beyond the few hundred cycles the tests need.
    initial begin
        #(8000 * 50);
        n_errors++;
        conclude();
    end

    // Main sequence: reset values, NMI timing, masking, priority, two-level mode.
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rstn <= 1'b1;
        xfer(0, tma_pkg::OFF_SYSCTL, 0);
        chk(rd, 32'h0000_0001);
        xfer(0, tma_pkg::OFF_PRIO_A, 0);
        chk(rd, 32'h0000_0000);
        xfer(0, 8'h20, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        for (int m = 0; m < 3; m++) begin
            xfer(1, tma_pkg::OFF_MEMCFG, m);
            nmi <= 1'b1;
            serve(1, tma_pkg::NMI_VEC, 3 * (4 + 4 * m) + 5);
            nmi <= 1'b0;
        end
        // Standby hides a fresh non-maskable edge; the wait pin stretches three-state access.
        stby <= 1'b1;
        nmi <= 1'b1;
        repeat (8) @(posedge i_mclk);
        chk(busy, 1'b0);
        stby <= 1'b0;
        nmi <= 1'b0;
        hold = 4;
        xfer(1, tma_pkg::OFF_MEMCFG, 2);
        nmi <= 1'b1;
        serve(1, tma_pkg::NMI_VEC, 45);
        nmi <= 1'b0;
        hold = 0;
        xfer(1, tma_pkg::OFF_MEMCFG, 0);
        xfer(1, tma_pkg::OFF_ENABLE, 32'h0000_0090);
        per <= 25'h000_0009;
        serve(0, 0, 0);
        xfer(1, tma_pkg::OFF_CCR, 0);
        serve(1, tma_pkg::SRC_VEC[4], 17);
        chk(sccr, 0);
        chk(condition_code_reg, 8'h80);
        per <= 25'h000_0008;
        xfer(1, tma_pkg::OFF_CCR, 0);
        serve(1, tma_pkg::SRC_VEC[7], 17);
        per <= 25'h000_0010;
        xfer(1, tma_pkg::OFF_CCR, 0);
        serve(0, 0, 0);
        xfer(1, tma_pkg::OFF_PRIO_A, 32'h0000_0004);
        per <= 25'h000_0009;
        serve(1, tma_pkg::SRC_VEC[7], 17);
        per <= 25'h000_0001;
        xfer(1, tma_pkg::OFF_SYSCTL, 0);
        serve(0, 0, 0);
        ext <= 4'h1;
        xfer(1, tma_pkg::OFF_ENABLE, 32'h0000_0091);
        xfer(1, tma_pkg::OFF_PRIO_A, 32'h0000_0080);
        serve(1, tma_pkg::SRC_VEC[0], 17);
        chk(condition_code_reg, 8'hC0);
        ext <= 4'h0;
        serve(0, 0, 0);
        xfer(1, tma_pkg::OFF_CCR, 32'h0000_0040);
        serve(1, tma_pkg::SRC_VEC[4], 17);
        conclude();
    end
endmodule : tb_tma_arbiter
